//--- logic/pvl_pkg.sv
/*
 * Constants, field layouts and carrier types for the vendor link status
 * register pair and its serial management slave.
 * Assumes one core clock domain; management pins arrive asynchronously.
 */
package pvl_pkg;

    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [4:0] REG_CTRL_ADDR = 5'h10;
    localparam logic [4:0] REG_STAT_ADDR = 5'h11;

    // ----------------------------------------
    // Field layout and speed codes
    // ----------------------------------------
    localparam int CTRL_LSB = 10;
    localparam int STAT_LSB = 9;
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;

    // ----------------------------------------
    // Management frame
    // ----------------------------------------
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [5:0] PRE_LEN = 6'h20;
    localparam logic [3:0] HDR_LAST = 4'hC;
    localparam logic [3:0] DAT_LAST = 4'hF;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [4:0] PHY_ADDR_DEF = 5'h01;

    // Control bits 15:10, msb first
    typedef struct packed {
        logic [1:0] display;
        logic current;
        logic rsvd;
        logic downshift;
        logic heartbeat;
    } pvl_ctrl_type;

    localparam pvl_ctrl_type CTRL_RST = 6'h06;

    // Status bits 15:9, msb first
    typedef struct packed {
        logic link_up;
        logic [1:0] speed;
        logic duplex;
        logic mdix;
        logic sleep;
        logic jabber;
    } pvl_status_type;

    localparam pvl_status_type STAT_RST = 7'h00;

endpackage

//--- logic/pvl_regs.sv
/*
 * Vendor control and link status registers behind a serial management slave.
 * Assumes the management clock is at most a quarter of the core clock and that
 * status inputs and the gigabit failure pulse come from core-clock logic.
 */
`timescale 1ns/10ps
module pvl_regs #(
    parameter logic [4:0] PHY_ADDR = pvl_pkg::PHY_ADDR_DEF
) (
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    // Management pins
    input wire logic I_MDC,
    input wire logic I_MDIO,
    output logic O_MDIO_OUT,
    output logic O_MDIO_OE,
    // Strap and link state
    input wire logic I_LED_MODE_STRAP,
    input wire pvl_pkg::pvl_status_type I_STATUS,
    input wire logic I_GIG_LINK_FAIL,
    // Control outputs
    output pvl_pkg::pvl_ctrl_type O_CTRL,
    output logic O_FALLBACK_100
);

    // ----------------------------------------
    // Synchronisers and snapshots
    // ----------------------------------------
    logic mdc_s1_r, mdc_s2_r, mdc_s3_r, mdio_s1_r, mdio_s2_r;
    logic strap_s1_r, strap_s2_r;
    pvl_pkg::pvl_status_type stat_r;
    logic rise;

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            mdc_s1_r <= 1'b0;
            mdc_s2_r <= 1'b0;
            mdc_s3_r <= 1'b0;
            mdio_s1_r <= 1'b1;
            mdio_s2_r <= 1'b1;
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
            stat_r <= pvl_pkg::STAT_RST;
        end
        else
        begin
            mdc_s1_r <= I_MDC;
            mdc_s2_r <= mdc_s1_r;
            mdc_s3_r <= mdc_s2_r;
            mdio_s1_r <= I_MDIO;
            mdio_s2_r <= mdio_s1_r;
            strap_s1_r <= I_LED_MODE_STRAP;
            strap_s2_r <= strap_s1_r;
            stat_r <= I_STATUS;
        end
    end

    assign rise = mdc_s2_r & ~mdc_s3_r;

    // Status word; masked while link is down so stale speed never shows
    function automatic logic [15:0] stat_word(input pvl_pkg::pvl_status_type s);
        logic [15:0] w;
        w = 16'h0000;
        w[pvl_pkg::STAT_LSB +: 7] = s;
        w[15:12] = s.link_up ? w[15:12] : 4'h0;
        return w;
    endfunction

    // ----------------------------------------
    // Frame state machine
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_PRE = 4'h1,
        ST_HDR = 4'h2,
        ST_TA = 4'h4,
        ST_DAT = 4'h8
    } pvl_state_type;

    pvl_state_type state_r, state_nxt;
    logic [5:0] ones_r, ones_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [11:0] hdr_r, hdr_nxt;
    logic [15:0] dat_r, dat_nxt;
    logic rd_r, rd_nxt, is_ctrl_r, is_ctrl_nxt;
    logic out_r, out_nxt, oe_r, oe_nxt;
    logic [12:0] hdr_full;
    logic [15:0] wdata;
    logic commit_ctrl, rd_stat_go;

    assign hdr_full = {hdr_r, mdio_s2_r};
    assign wdata = {dat_r[14:0], mdio_s2_r};

    always_comb
    begin
        state_nxt = state_r;
        ones_nxt = ones_r;
        cnt_nxt = cnt_r;
        hdr_nxt = hdr_r;
        dat_nxt = dat_r;
        rd_nxt = rd_r;
        is_ctrl_nxt = is_ctrl_r;
        out_nxt = out_r;
        oe_nxt = oe_r;
        commit_ctrl = 1'b0;
        rd_stat_go = 1'b0;
        if (rise)
        begin
            case (state_r)
                ST_PRE:
                begin
                    if (mdio_s2_r)
                    begin
                        ones_nxt = (ones_r == pvl_pkg::PRE_LEN) ? ones_r : ones_r + 6'h01;
                    end
                    else
                    begin
                        state_nxt = (ones_r == pvl_pkg::PRE_LEN) ? ST_HDR : ST_PRE;
                        ones_nxt = 6'h00;
                        cnt_nxt = 4'h0;
                    end
                end
                ST_HDR:
                begin
                    hdr_nxt = hdr_full[11:0];
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == pvl_pkg::HDR_LAST)
                    begin
                        // Only this address; other stations stay silent
                        state_nxt = ST_PRE;
                        cnt_nxt = 4'h0;
                        is_ctrl_nxt = hdr_full[4:0] == pvl_pkg::REG_CTRL_ADDR;
                        if (hdr_full[12] && hdr_full[9:5] == PHY_ADDR)
                        begin
                            if (hdr_full[11:10] == pvl_pkg::OP_WRITE)
                            begin
                                state_nxt = ST_TA;
                                rd_nxt = 1'b0;
                            end
                            else if (hdr_full[11:10] == pvl_pkg::OP_READ
                                     && (is_ctrl_nxt || hdr_full[4:0] == pvl_pkg::REG_STAT_ADDR))
                            begin
                                state_nxt = ST_TA;
                                rd_nxt = 1'b1;
                                rd_stat_go = !is_ctrl_nxt;
                                dat_nxt = is_ctrl_nxt ? {O_CTRL, 10'h000}
                                    : stat_word(stat_r);
                            end
                        end
                    end
                end
                ST_TA:
                begin
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == 4'h0)
                    begin
                        oe_nxt = rd_r;
                        out_nxt = 1'b0;
                    end
                    else
                    begin
                        state_nxt = ST_DAT;
                        cnt_nxt = 4'h0;
                        out_nxt = dat_r[15];
                    end
                end
                ST_DAT:
                begin
                    cnt_nxt = cnt_r + 4'h1;
                    // Out on reads, in on writes; line value unused while released
                    out_nxt = dat_r[14];
                    dat_nxt = rd_r ? {dat_r[14:0], 1'b0} : wdata;
                    if (cnt_r == pvl_pkg::DAT_LAST)
                    begin
                        state_nxt = ST_PRE;
                        oe_nxt = 1'b0;
                        out_nxt = 1'b0;
                        commit_ctrl = !rd_r && is_ctrl_r;
                    end
                end
                default:
                begin
                    state_nxt = ST_PRE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            state_r <= ST_PRE;
            ones_r <= 6'h00;
            cnt_r <= 4'h0;
            hdr_r <= 12'h000;
            dat_r <= 16'h0000;
            rd_r <= 1'b0;
            is_ctrl_r <= 1'b0;
            out_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ones_r <= ones_nxt;
            cnt_r <= cnt_nxt;
            hdr_r <= hdr_nxt;
            dat_r <= dat_nxt;
            rd_r <= rd_nxt;
            is_ctrl_r <= is_ctrl_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign O_MDIO_OUT = out_r;
    assign O_MDIO_OE = oe_r;

    // ----------------------------------------
    // Control register and fallback
    // ----------------------------------------
    pvl_pkg::pvl_ctrl_type ctrl_r, ctrl_nxt;
    logic [1:0] init_r, init_nxt;
    logic fb_r, fb_nxt;
    logic strap_cap;

    assign strap_cap = init_r == pvl_pkg::STRAP_SETTLE;

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        init_nxt = (init_r == pvl_pkg::STRAP_SETTLE + 2'h1) ? init_r : init_r + 2'h1;
        // Strap sampled only once, after its synchroniser has filled
        if (strap_cap)
        begin
            ctrl_nxt.display[0] = strap_s2_r;
        end
        if (commit_ctrl)
        begin
            ctrl_nxt = wdata[15:pvl_pkg::CTRL_LSB];
        end
        // Failure pulse sets, disable clears; the clear wins in its own cycle
        fb_nxt = ctrl_r.downshift & (fb_r | I_GIG_LINK_FAIL);
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            ctrl_r <= pvl_pkg::CTRL_RST;
            init_r <= 2'h0;
            fb_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            init_r <= init_nxt;
            fb_r <= fb_nxt;
        end
    end

    assign O_CTRL = ctrl_r;
    assign O_FALLBACK_100 = fb_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RSTN);

    sequence stat_load_s;
        rd_stat_go;
    endsequence

    heartbeat_write_a: assert property (commit_ctrl |=> O_CTRL.heartbeat == $past(wdata[10]))
        else $error("heartbeat bit not written");
    fallback_set_a: assert property (O_CTRL.downshift && I_GIG_LINK_FAIL |=> O_FALLBACK_100)
        else $error("fallback not raised");
    fallback_off_a: assert property (!O_CTRL.downshift |=> !O_FALLBACK_100)
        else $error("fallback while downshift off");
    current_write_a: assert property (commit_ctrl |=> O_CTRL.current == $past(wdata[13]))
        else $error("indicator current not written");
    strap_load_a: assert property (strap_cap && !commit_ctrl
        |=> O_CTRL.display[0] == $past(strap_s2_r))
        else $error("strap not loaded");
    jabber_read_a: assert property (stat_load_s
        |=> dat_r[9:0] == {$past(stat_r.jabber), 9'h000})
        else $error("jabber or reserved bits wrong");
    link_mask_a: assert property (stat_load_s ##0 !stat_r.link_up |=> dat_r[15:12] == 4'h0)
        else $error("speed shown while link down");
    speed_read_a: assert property (stat_load_s ##0 stat_r.link_up
        |=> dat_r[14:12] == $past({stat_r.speed, stat_r.duplex}))
        else $error("speed or duplex wrong");
    sleep_mdix_a: assert property (stat_load_s
        |=> dat_r[11:10] == $past({stat_r.mdix, stat_r.sleep}))
        else $error("sleep or crossover wrong");

endmodule

//--- sim/pvl_smi_master.sv
/*
 * Station management controller model: makes the management clock and
 * frames, samples the shared data line on the clock rises of the second turnaround bit and the data bits.
 * Assumes the bench resolves the line with a pull-up when nobody drives.
 */
`timescale 1ns/10ps
module pvl_smi_master (
    // Clock
    input wire logic i_clk,
    // Management line
    input wire logic i_mdio,
    output logic o_mdc,
    output logic o_mdio,
    output logic o_mdio_oe
);
    initial
    begin
        o_mdc = 1'b0;
        o_mdio = 1'b1;
        o_mdio_oe = 1'b0;
    end

    // ----------------------------------------
    // Frame: 64 clocks of 8 core cycles
    // ----------------------------------------
    // Clock stands still between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] reg_addr,
        input logic [15:0] wdata, input logic [4:0] phy,
        output logic [15:0] rdata, output logic ta);
        logic [63:0] bits;
        bits = {32'hFFFFFFFF, 2'b01, op, phy, reg_addr, 2'b10, wdata};
        rdata = 16'hFFFF;
        ta = 1'b1;
        if (reg_addr == 5'h12 || reg_addr == 5'h13)
            return;
        for (int i = 63; i >= 0; i--)
        begin
            @(posedge i_clk);
            #1;
            o_mdc = 1'b0;
            o_mdio_oe = (op == pvl_pkg::OP_WRITE) || (i > 17);
            o_mdio = bits[i];
            repeat (4) @(posedge i_clk);
            #1;
            o_mdc = 1'b1;
            if (i == 16)
                ta = i_mdio;
            if (i < 16)
                rdata[i] = i_mdio;
            repeat (3) @(posedge i_clk);
        end
        o_mdio_oe = 1'b0;
        // Let the device release before the next preamble
        repeat (6) @(posedge i_clk);
    endtask
endmodule

//--- sim/test_pvl_regs.sv
/*
 * Self-checking bench for the vendor control and link status registers.
 * Assumes the design samples management pins through its own synchronisers.
 */
`timescale 1ns/10ps
module test_pvl_regs;
    logic clk;
    logic rstn;
    logic mdc;
    logic m_out;
    logic m_oe;
    logic strap;
    logic fail;
    logic d_out;
    logic d_oe;
    logic fb;
    logic mdio;
    pvl_pkg::pvl_status_type status;
    pvl_pkg::pvl_ctrl_type ctrl;
    int n_errors;
    int checked;
    logic [15:0] rd;
    logic ta;
    logic [5:0] ctl_tbl [4] = '{6'h2F, 6'h3E, 6'h1F, 6'h0E};
    logic [6:0] st_tbl [5] = '{7'h69, 7'h54, 7'h48, 7'h2F, 7'h02};

    // Pull-up when the line is released
    assign mdio = d_oe ? d_out : (m_oe ? m_out : 1'b1);

    pvl_regs #(.PHY_ADDR(pvl_pkg::PHY_ADDR_DEF)) DUT (
        .I_CORE_CLK(clk), .I_RSTN(rstn), .I_MDC(mdc), .I_MDIO(mdio),
        .O_MDIO_OUT(d_out), .O_MDIO_OE(d_oe), .I_LED_MODE_STRAP(strap),
        .I_STATUS(status), .I_GIG_LINK_FAIL(fail), .O_CTRL(ctrl), .O_FALLBACK_100(fb));

    pvl_smi_master u_mst (.i_clk(clk), .i_mdio(mdio), .o_mdc(mdc), .o_mdio(m_out),
        .o_mdio_oe(m_oe));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] stat_exp(input logic [6:0] s);
        stat_exp = s[6] ? {s, 9'h000} : {4'h0, s[2:0], 9'h000};
    endfunction

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic rd_reg(input logic [4:0] a, input logic [4:0] phy);
        u_mst.frame(pvl_pkg::OP_READ, a, 16'h0000, phy, rd, ta);
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] unused_d;
        logic unused_t;
        u_mst.frame(pvl_pkg::OP_WRITE, a, d, pvl_pkg::PHY_ADDR_DEF, unused_d, unused_t);
        repeat (2) @(posedge clk);
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog, tests
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // About three times the expected run
    initial
    begin
        #3000000;
        n_errors++;
        final_report();
    end

    initial
    begin
        rstn = 1'b0;
        strap = 1'b1;
        fail = 1'b0;
        status = 7'h00;
        n_errors = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        #1;
        chk16("ctrl in reset", 16'h0006, {10'h000, ctrl});
        chk1("fallback in reset", 1'b0, fb);
        rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk16("ctrl after reset", 16'h0016, {10'h000, ctrl});
        rd_reg(pvl_pkg::REG_CTRL_ADDR, pvl_pkg::PHY_ADDR_DEF);
        chk1("turnaround", 1'b0, ta);
        chk16("ctrl read", 16'h5800, rd);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(pvl_pkg::REG_CTRL_ADDR, {ctl_tbl[i], 10'h3FF});
            #1;
            chk16("ctrl port", {10'h000, ctl_tbl[i]}, {10'h000, ctrl});
            rd_reg(pvl_pkg::REG_CTRL_ADDR, pvl_pkg::PHY_ADDR_DEF);
            chk16("ctrl readback", {ctl_tbl[i], 10'h000}, rd);
        end
        $display("test control done");
        @(posedge clk);
        #1 fail = 1'b1;
        @(posedge clk);
        #1 fail = 1'b0;
        @(posedge clk);
        #1;
        chk1("fallback set", 1'b1, fb);
        wr_reg(pvl_pkg::REG_CTRL_ADDR, 16'h3000);
        #1;
        chk1("fallback cleared", 1'b0, fb);
        fail = 1'b1;
        @(posedge clk);
        #1 fail = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk1("no fallback", 1'b0, fb);
        $display("test downshift done");
        for (int i = 0; i < 5; i++)
        begin
            #1 status = st_tbl[i];
            rd_reg(pvl_pkg::REG_STAT_ADDR, pvl_pkg::PHY_ADDR_DEF);
            chk16("status read", stat_exp(st_tbl[i]), rd);
        end
        $display("test status done");
        wr_reg(pvl_pkg::REG_STAT_ADDR, 16'hFFFF);
        rd_reg(pvl_pkg::REG_STAT_ADDR, pvl_pkg::PHY_ADDR_DEF);
        chk16("status after write", stat_exp(st_tbl[4]), rd);
        rd_reg(5'h0F, pvl_pkg::PHY_ADDR_DEF);
        chk16("unmapped read", 16'hFFFF, rd);
        chk1("unmapped turnaround", 1'b1, ta);
        rd_reg(pvl_pkg::REG_CTRL_ADDR, 5'h02);
        chk16("other address read", 16'hFFFF, rd);
        rd_reg(pvl_pkg::REG_CTRL_ADDR, pvl_pkg::PHY_ADDR_DEF);
        chk16("ctrl kept", 16'h3000, rd);
        $display("test refusal done");
        final_report();
    end
endmodule
